/* rtl/iex_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iex_params.svh"
// Function
// - halt instruction clears watchdog counter and its prescaler to zero.
// - halt sets watchdog expiry flag, clears power-down flag, other flags kept.
// - halt enters low-power state with main oscillator stopped.
// - return pops stack into program counter, two cycles, flags unchanged.
// - literal minus accumulator into accumulator, updates carry, half carry, zero.
// - file minus accumulator, updates carry, half carry, zero; 7-bit file address.
// - destination bit 0 writes accumulator, 1 writes the file register back.
// - rotate file right through carry, only carry changes, result to destination.
// - swap file nibbles into destination, no flags change.
// - accumulator xor literal into accumulator, only zero flag changes.
// - accumulator xor file into destination, only zero flag changes.
module iex_core (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire iex_pkg::iex_op_t op_code,
  input wire logic [`IEX_DATA_W-1:0] op_literal,
  input wire logic [`IEX_ADDR_W-1:0] op_file_addr,
  input wire logic op_dest,
  input wire logic [`IEX_DATA_W-1:0] file_rdata,
  input wire logic wake,
  input wire logic wdt_tick,
  input wire logic push_valid,
  input wire logic [`IEX_PC_W-1:0] push_pc,
  output logic op_ready,
  output logic [`IEX_ADDR_W-1:0] file_addr,
  output logic file_we,
  output logic [`IEX_DATA_W-1:0] file_wdata,
  output logic [`IEX_DATA_W-1:0] acc,
  output logic [`IEX_DATA_W-1:0] status,
  output logic [`IEX_PC_W-1:0] pc,
  output logic pc_load,
  output logic [`IEX_WDT_W-1:0] wdt_count,
  output logic [`IEX_PRE_W-1:0] wdt_prescale,
  output logic osc_run,
  output logic sleeping
);
  ////////////////////////////////////////////////////////////////////////////
  // subtraction a - b with no-borrow carry and half carry
  function automatic logic [`IEX_DATA_W+1:0] iex_sub(input logic [`IEX_DATA_W-1:0] a,
                                                   input logic [`IEX_DATA_W-1:0] b);
    logic [`IEX_DATA_W:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, ~b} + 9'h001;
    low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    return {low[4], full[`IEX_DATA_W], full[`IEX_DATA_W-1:0]};
  endfunction

  iex_pkg::iex_state_t state_reg, state_next;
  logic [`IEX_DATA_W-1:0] acc_reg, acc_next;
  logic [`IEX_DATA_W-1:0] status_reg, status_next;
  logic [`IEX_PC_W-1:0] pc_reg, pc_next;
  logic pc_load_reg, pc_load_next;
  logic file_we_reg, file_we_next;
  logic [`IEX_DATA_W-1:0] file_wdata_reg, file_wdata_next;
  logic [`IEX_ADDR_W-1:0] file_addr_reg, file_addr_next;
  logic [`IEX_WDT_W-1:0] wdt_reg, wdt_next;
  logic [`IEX_PRE_W-1:0] pre_reg, pre_next;
  logic [`IEX_PC_W-1:0] stack_reg [`IEX_STACK_DEPTH];
  logic [`IEX_PC_W-1:0] stack_next [`IEX_STACK_DEPTH];
  logic [2:0] sp_reg, sp_next;
  logic wake_s1_reg, wake_s2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // wake pin synchroniser
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
    end else begin
      wake_s1_reg <= wake;
      wake_s2_reg <= wake_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic for the datapath
  always_comb begin
    logic [`IEX_DATA_W+1:0] diff;
    logic [`IEX_DATA_W-1:0] res;
    logic [2:0] sp_dec;
    diff = '0;
    res = '0;
    sp_dec = sp_reg - 3'h1;
    state_next = state_reg;
    acc_next = acc_reg;
    status_next = status_reg;
    pc_next = pc_reg;
    pc_load_next = 1'b0;
    file_we_next = 1'b0;
    file_wdata_next = file_wdata_reg;
    file_addr_next = op_file_addr;
    wdt_next = wdt_reg;
    pre_next = pre_reg;
    sp_next = sp_reg;
    for (int i = 0; i < `IEX_STACK_DEPTH; i++) begin
      stack_next[i] = stack_reg[i];
    end
    // watchdog prescaler advances on each tick, counter only on a tick that wraps the prescaler from ff
    if (wdt_tick) begin
      pre_next = pre_reg + 8'h01;
      if (pre_reg == 8'hff) begin
        wdt_next = wdt_reg + 8'h01;
      end
    end
    // call pushes come from the sequencer outside this datapath
    if (push_valid && state_reg == iex_pkg::IEX_S_RUN) begin
      stack_next[sp_reg] = push_pc;
      sp_next = sp_reg + 3'h1;
    end
    case (state_reg)
      iex_pkg::IEX_S_RUN: begin
        if (op_valid) begin
          case (op_code)
            iex_pkg::IEX_SLEEP: begin
              wdt_next = `IEX_WDT_CLEAR;
              pre_next = `IEX_PRE_CLEAR;
              status_next[`IEX_ST_EXP] = 1'b1;
              status_next[`IEX_ST_PWD] = 1'b0;
              state_next = iex_pkg::IEX_S_HALT;
            end
            iex_pkg::IEX_RET: begin
              sp_next = sp_dec;
              pc_next = stack_reg[sp_dec];
              pc_load_next = 1'b1;
              state_next = iex_pkg::IEX_S_RET2;
            end
            iex_pkg::IEX_SUBL, iex_pkg::IEX_SUBF: begin
              if (op_code == iex_pkg::IEX_SUBL) begin
                diff = iex_sub(op_literal, acc_reg);
              end else begin
                diff = iex_sub(file_rdata, acc_reg);
              end
              res = diff[`IEX_DATA_W-1:0];
              status_next[`IEX_ST_C] = diff[`IEX_DATA_W];
              status_next[`IEX_ST_HC] = diff[`IEX_DATA_W+1];
              status_next[`IEX_ST_Z] = (res == 8'h00);
            end
            iex_pkg::IEX_RORC: begin
              res = {status_reg[`IEX_ST_C], file_rdata[`IEX_DATA_W-1:1]};
              status_next[`IEX_ST_C] = file_rdata[0];
            end
            iex_pkg::IEX_SWAP: begin
              res = {file_rdata[3:0], file_rdata[7:4]};
            end
            iex_pkg::IEX_XORL, iex_pkg::IEX_XORF: begin
              if (op_code == iex_pkg::IEX_XORL) begin
                res = acc_reg ^ op_literal;
              end else begin
                res = acc_reg ^ file_rdata;
              end
              status_next[`IEX_ST_Z] = (res == 8'h00);
            end
            default: begin
            end
          endcase
          // result routing: literal ops always to the accumulator
          case (op_code)
            iex_pkg::IEX_SUBL, iex_pkg::IEX_XORL: begin
              acc_next = res;
            end
            iex_pkg::IEX_SUBF, iex_pkg::IEX_RORC, iex_pkg::IEX_SWAP, iex_pkg::IEX_XORF: begin
              if (op_dest) begin
                file_we_next = 1'b1;
                file_wdata_next = res;
              end else begin
                acc_next = res;
              end
            end
            default: begin
            end
          endcase
        end
      end
      iex_pkg::IEX_S_RET2: begin
        state_next = iex_pkg::IEX_S_RUN;
      end
      iex_pkg::IEX_S_HALT: begin
        if (wake_s2_reg) begin
          state_next = iex_pkg::IEX_S_RUN;
        end
      end
      default: begin
        state_next = iex_pkg::IEX_S_RUN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // datapath registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= iex_pkg::IEX_S_RUN;
      acc_reg <= 8'h00;
      status_reg <= `IEX_STATUS_RST;
      pc_reg <= 13'h0000;
      pc_load_reg <= 1'b0;
      file_we_reg <= 1'b0;
      file_wdata_reg <= 8'h00;
      file_addr_reg <= 7'h00;
      wdt_reg <= `IEX_WDT_CLEAR;
      pre_reg <= `IEX_PRE_CLEAR;
      sp_reg <= 3'h0;
      for (int i = 0; i < `IEX_STACK_DEPTH; i++) begin
        stack_reg[i] <= 13'h0000;
      end
    end else begin
      state_reg <= state_next;
      acc_reg <= acc_next;
      status_reg <= status_next;
      pc_reg <= pc_next;
      pc_load_reg <= pc_load_next;
      file_we_reg <= file_we_next;
      file_wdata_reg <= file_wdata_next;
      file_addr_reg <= file_addr_next;
      wdt_reg <= wdt_next;
      pre_reg <= pre_next;
      sp_reg <= sp_next;
      for (int i = 0; i < `IEX_STACK_DEPTH; i++) begin
        stack_reg[i] <= stack_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign op_ready = (state_reg == iex_pkg::IEX_S_RUN);
  assign osc_run = (state_reg != iex_pkg::IEX_S_HALT);
  assign sleeping = (state_reg == iex_pkg::IEX_S_HALT);
  assign acc = acc_reg;
  assign status = status_reg;
  assign pc = pc_reg;
  assign pc_load = pc_load_reg;
  assign file_we = file_we_reg;
  assign file_wdata = file_wdata_reg;
  assign file_addr = file_addr_reg;
  assign wdt_count = wdt_reg;
  assign wdt_prescale = pre_reg;
endmodule
`default_nettype wire

/* shared/iex_params.svh */
`ifndef IEX_PARAMS_SVH
`define IEX_PARAMS_SVH
// data and address widths
`define IEX_DATA_W 8
`define IEX_ADDR_W 7
`define IEX_PC_W 13
`define IEX_STACK_DEPTH 8
`define IEX_WDT_W 8
`define IEX_PRE_W 8
// status field positions
`define IEX_ST_C 0
`define IEX_ST_HC 1
`define IEX_ST_Z 2
`define IEX_ST_PWD 3
`define IEX_ST_EXP 4
// reset values
`define IEX_STATUS_RST 8'h18
`define IEX_WDT_CLEAR 8'h00
`define IEX_PRE_CLEAR 8'h00
// cycles taken by the return
`define IEX_RET_CYCLES 2'h2
`endif

/* shared/iex_pkg.sv */
package iex_pkg;
  // operations decoded by the core ahead of this datapath
  typedef enum logic [3:0] {
    IEX_NOP = 4'h0,
    IEX_SLEEP = 4'h1,
    IEX_RET = 4'h2,
    IEX_SUBL = 4'h3,
    IEX_SUBF = 4'h4,
    IEX_RORC = 4'h5,
    IEX_SWAP = 4'h6,
    IEX_XORL = 4'h7,
    IEX_XORF = 4'h8
  } iex_op_t;
  // control states, one-hot
  typedef enum logic [2:0] {
    IEX_S_RUN = 3'b001,
    IEX_S_RET2 = 3'b010,
    IEX_S_HALT = 3'b100
  } iex_state_t;
endpackage

/* tb/iex_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module iex_core_asserts (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire iex_pkg::iex_op_t op_code,
  input wire logic [7:0] op_literal,
  input wire logic op_dest,
  input wire logic op_ready,
  input wire logic file_we,
  input wire logic [7:0] acc,
  input wire logic [7:0] status,
  input wire logic pc_load,
  input wire logic [7:0] wdt_count,
  input wire logic [7:0] wdt_prescale,
  input wire logic osc_run,
  input wire logic sleeping
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // an operation is taken on this edge
  logic go;
  assign go = op_valid && op_ready;
  ////////////////////////////////////////////////////////////////
  AST_SLP_WDT: assert property (
    go && op_code == iex_pkg::IEX_SLEEP |=> wdt_count == 8'h00 && wdt_prescale == 8'h00)
    else $error("halt left watchdog uncleared");
  AST_SLP_FLG: assert property (
    go && op_code == iex_pkg::IEX_SLEEP |=> status[4:3] == 2'b10 && status[2:0] == $past(status[2:0]))
    else $error("halt flags wrong");
  AST_SLP_OSC: assert property (
    go && op_code == iex_pkg::IEX_SLEEP |=> (!osc_run && sleeping) [*2])
    else $error("oscillator not stopped");
  AST_RET: assert property (
    go && op_code == iex_pkg::IEX_RET |=> pc_load && !op_ready && $stable(status) ##1 op_ready)
    else $error("return timing wrong");
  AST_SUBL: assert property (
    go && op_code == iex_pkg::IEX_SUBL |=> acc == 8'($past(op_literal) - $past(acc)))
    else $error("literal subtract wrong");
  AST_DEST: assert property (
    go && op_code inside {iex_pkg::IEX_SUBF, iex_pkg::IEX_RORC, iex_pkg::IEX_SWAP, iex_pkg::IEX_XORF}
    |=> file_we == $past(op_dest))
    else $error("destination select wrong");
  AST_SWAP: assert property (
    go && op_code == iex_pkg::IEX_SWAP |=> $stable(status))
    else $error("swap touched flags");
  AST_XORL: assert property (
    go && op_code == iex_pkg::IEX_XORL |=> acc == ($past(acc) ^ $past(op_literal))
    && status[1:0] == $past(status[1:0]) && status[2] == (acc == 8'h00))
    else $error("literal xor wrong");
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock, rst_b, op_valid, op_dest, wake, wdt_tick, push_valid, file_we, pc_load, osc_run, sleeping, op_ready;
  iex_pkg::iex_op_t op_code;
  logic [7:0] op_literal, file_rdata, file_wdata, acc, status, wdt_count, wdt_prescale;
  logic [6:0] op_file_addr, file_addr;
  logic [12:0] push_pc, pc;
  int n_mismatch = 0;
  int checked = 0;
  iex_core dut_u (.clock(clock), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code), .op_literal(op_literal),
    .op_file_addr(op_file_addr), .op_dest(op_dest), .file_rdata(file_rdata), .wake(wake), .wdt_tick(wdt_tick),
    .push_valid(push_valid), .push_pc(push_pc), .op_ready(op_ready), .file_addr(file_addr), .file_we(file_we),
    .file_wdata(file_wdata), .acc(acc), .status(status), .pc(pc), .pc_load(pc_load), .wdt_count(wdt_count),
    .wdt_prescale(wdt_prescale), .osc_run(osc_run), .sleeping(sleeping));
  ////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // compare one value, widest packed result is 17 bits
  task automatic chk(logic [16:0] got, logic [16:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // issue one operation, results are settled on return
  task automatic do_op(iex_pkg::iex_op_t c, logic [7:0] k, logic [7:0] f, logic d);
    @(posedge clock);
    op_valid <= 1'b1;
    op_code <= c;
    op_literal <= k;
    file_rdata <= f;
    op_dest <= d;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    rst_b <= 1'b0;
    op_valid <= 1'b0;
    op_code <= iex_pkg::IEX_NOP;
    op_literal <= 8'h00;
    op_file_addr <= 7'h7f;
    op_dest <= 1'b0;
    file_rdata <= 8'h00;
    wake <= 1'b0;
    wdt_tick <= 1'b0;
    push_valid <= 1'b0;
    push_pc <= 13'h0000;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    chk(17'(status), 17'h00018);
    do_op(iex_pkg::IEX_XORL, 8'h5a, 8'h00, 1'b0);
    chk(17'(acc), 17'h0005a);
    do_op(iex_pkg::IEX_XORL, 8'h5a, 8'h00, 1'b0);
    chk(17'(status), 17'h0001c);
    do_op(iex_pkg::IEX_SUBL, 8'h10, 8'h00, 1'b0);
    chk(17'(status), 17'h0001b);
    do_op(iex_pkg::IEX_SUBL, 8'h05, 8'h00, 1'b0);
    chk(17'({acc, status}), 17'h0f51a);
    do_op(iex_pkg::IEX_SUBF, 8'h00, 8'hf5, 1'b0);
    chk(17'({acc, status}), 17'h0001f);
    do_op(iex_pkg::IEX_XORL, 8'h01, 8'h00, 1'b0);
    chk(17'(status), 17'h0001b);
    do_op(iex_pkg::IEX_SUBF, 8'h00, 8'h00, 1'b1);
    chk(17'({file_we, file_addr, file_wdata}), 17'h0ffff);
    chk(17'({acc, status}), 17'h00118);
    do_op(iex_pkg::IEX_RORC, 8'h00, 8'h81, 1'b0);
    chk(17'({acc, status}), 17'h04019);
    do_op(iex_pkg::IEX_SWAP, 8'h00, 8'h3c, 1'b1);
    chk({file_we, file_wdata, status}, 17'h1c319);
    do_op(iex_pkg::IEX_XORF, 8'h00, 8'h40, 1'b0);
    chk({file_we, acc, status}, 17'h0001d);
    @(posedge clock);
    push_valid <= 1'b1;
    push_pc <= 13'h1abc;
    @(posedge clock);
    push_valid <= 1'b0;
    do_op(iex_pkg::IEX_RET, 8'h00, 8'h00, 1'b0);
    chk(17'({pc_load, op_ready, pc}), 17'h05abc);
    @(posedge clock);
    #1;
    chk(17'(op_ready), 17'h00001);
    // run the prescaler past one wrap so the counter is nonzero before the halt
    @(posedge clock);
    wdt_tick <= 1'b1;
    repeat (257) @(posedge clock);
    wdt_tick <= 1'b0;
    #1;
    chk(17'({wdt_count, wdt_prescale}), 17'h00101);
    do_op(iex_pkg::IEX_SLEEP, 8'h00, 8'h00, 1'b0);
    chk(17'({wdt_count, wdt_prescale}), 17'h00000);
    chk(17'(status), 17'h00015);
    chk(17'({osc_run, sleeping}), 17'h00001);
    do_op(iex_pkg::IEX_XORL, 8'hff, 8'h00, 1'b0);
    chk(17'({acc, status}), 17'h00015);
    @(posedge clock);
    wake <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    chk(17'({osc_run, sleeping}), 17'h00002);
    give_verdict();
  end
endmodule
bind iex_core iex_core_asserts chk_u (.clock(clock), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
  .op_literal(op_literal), .op_dest(op_dest), .op_ready(op_ready), .file_we(file_we), .acc(acc), .status(status),
  .pc_load(pc_load), .wdt_count(wdt_count), .wdt_prescale(wdt_prescale), .osc_run(osc_run), .sleeping(sleeping));
`default_nettype wire
